//--- logic/wpr_top.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "wpr_defs.svh"
module wpr_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rst_pin,
    input wire logic cpu_irq,
    output logic sys_reset,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic irq
);
    wpr_pkg::wpr_top_st_t st_reg;
    wpr_pkg::wpr_top_st_t st_next;

    logic pin_level;
    logic pin_rst;
    logic osc_on;
    logic mc_tick;
    logic state5_phase2_sample;
    logic filt_sample;
    logic in_reset;
    logic kick_do;
    logic kick_wr;
    logic wdt_tick;
    logic wdt_clr;
    logic wdt_timeout;
    logic wdt_fire;
    logic [13:0] wdt_count;
    logic access;
    wpr_pkg::wpr_sel_t sel;

    // Word index decode, shared by the read and write paths
    function automatic wpr_pkg::wpr_sel_t reg_sel(input logic [11:0] a);
        reg_sel = wpr_pkg::wpr_sel_none;
        if (a[1:0] == 2'b00) begin
            unique case (a[9:2])
                `WPR_IDX_POWER_CONTROL: reg_sel = wpr_pkg::wpr_sel_power_control;
                `WPR_IDX_WATCHDOG_CONTROL: reg_sel = wpr_pkg::wpr_sel_watchdog_control;
                `WPR_IDX_STAT: reg_sel = wpr_pkg::wpr_sel_stat;
                `WPR_IDX_MASK: reg_sel = wpr_pkg::wpr_sel_mask;
                default: reg_sel = wpr_pkg::wpr_sel_none;
            endcase
            if (a[11:10] != 2'b00) begin
                reg_sel = wpr_pkg::wpr_sel_none;
            end
        end
    endfunction

    function automatic logic [7:0] power_control_byte(input wpr_pkg::wpr_power_control_t p);
        power_control_byte = {3'b000, p.cold, p.uf1, p.uf0, p.deep, p.sleep};
    endfunction

    function automatic logic [7:0] watchdog_control_byte(input wpr_pkg::wpr_watchdog_control_t w);
        watchdog_control_byte = {w.run, w.kick, w.sleep_run, 2'b00, w.ps};
    endfunction

    wpr_rst_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .rst_pin(rst_pin),
        .sample_en(filt_sample),
        .pin_level(pin_level),
        .pin_rst(pin_rst)
    );

    wpr_wdt_core u_core (
        .pclk(pclk),
        .presetn(presetn),
        .clr(wdt_clr),
        .tick(wdt_tick),
        .ps(st_reg.watchdog_control.ps),
        .timeout(wdt_timeout),
        .count(wdt_count)
    );

    // Oscillator stands in deep stop until the reset pin rises
    assign osc_on = (st_reg.mode != wpr_pkg::wpr_mode_pdown) ||
        pin_level;
    assign mc_tick = osc_on && st_reg.phase &&
        (st_reg.stage == `WPR_LAST_STATE);
    assign state5_phase2_sample = osc_on && st_reg.phase &&
        (st_reg.stage == `WPR_SAMPLE_STATE);
    // Stopped oscillator means the pin is low: drop a half-counted high
    // sample so a later rise still needs two full samples
    assign filt_sample = state5_phase2_sample || !osc_on;
    assign in_reset = pin_rst || (st_reg.rst_cnt != 2'h0);
    assign access = psel && penable && st_reg.pready;
    assign sel = reg_sel(paddr);
    assign kick_wr = access && pwrite &&
        (sel == wpr_pkg::wpr_sel_watchdog_control) && pwdata[`WPR_WATCHDOG_CONTROL_KICK];
    // Kick acts at the next instruction cycle boundary; held in deep stop
    assign kick_do = st_reg.watchdog_control.kick && mc_tick &&
        (st_reg.mode != wpr_pkg::wpr_mode_pdown);
    assign wdt_clr = in_reset || kick_do;
    // Idle stops the count unless sleep-run is set; deep stop freezes it
    assign wdt_tick = mc_tick && st_reg.watchdog_control.run && !in_reset &&
        (st_reg.mode != wpr_pkg::wpr_mode_pdown) &&
        !((st_reg.mode == wpr_pkg::wpr_mode_idle) &&
        !st_reg.watchdog_control.sleep_run);
    assign wdt_fire = wdt_timeout && st_reg.watchdog_control.run;

    always_comb begin
        st_next = st_reg;

        // Clock divided by two, six states per machine cycle
        if (osc_on) begin
            st_next.phase = !st_reg.phase;
            if (st_reg.phase) begin
                if (st_reg.stage == `WPR_LAST_STATE) begin
                    st_next.stage = 3'h0;
                end else begin
                    st_next.stage = st_reg.stage + 3'h1;
                end
            end
        end

        // APB: one wait state, answer registered
        st_next.pready = psel && penable && !st_reg.pready;
        st_next.pslverr = 1'b0;
        if (psel && penable && !st_reg.pready) begin
            st_next.pslverr = (sel == wpr_pkg::wpr_sel_none);
            st_next.prdata = 32'h0000_0000;
            unique case (sel)
                wpr_pkg::wpr_sel_power_control:
                    st_next.prdata[7:0] = power_control_byte(st_reg.power_control);
                wpr_pkg::wpr_sel_watchdog_control:
                    st_next.prdata[7:0] = watchdog_control_byte(st_reg.watchdog_control);
                wpr_pkg::wpr_sel_stat:
                    st_next.prdata[2:0] = st_reg.stat;
                wpr_pkg::wpr_sel_mask:
                    st_next.prdata[2:0] = st_reg.mask;
                wpr_pkg::wpr_sel_none:
                    st_next.prdata = 32'h0000_0000;
            endcase
        end

        if (kick_do) begin
            st_next.watchdog_control.kick = 1'b0;
        end

        if (access && pwrite) begin
            unique case (sel)
                wpr_pkg::wpr_sel_power_control: begin
                    st_next.power_control.uf1 = pwdata[`WPR_POWER_CONTROL_UF1];
                    st_next.power_control.uf0 = pwdata[`WPR_POWER_CONTROL_UF0];
                    st_next.power_control.deep = pwdata[`WPR_POWER_CONTROL_DEEP];
                    st_next.power_control.sleep = pwdata[`WPR_POWER_CONTROL_SLEEP];
                    // Software can only clear the cold start flag
                    st_next.power_control.cold = st_reg.power_control.cold &&
                        pwdata[`WPR_POWER_CONTROL_COLD];
                end
                wpr_pkg::wpr_sel_watchdog_control: begin
                    st_next.watchdog_control.run = pwdata[`WPR_WATCHDOG_CONTROL_RUN];
                    st_next.watchdog_control.sleep_run = pwdata[`WPR_WATCHDOG_CONTROL_SLEEP];
                    st_next.watchdog_control.ps = pwdata[`WPR_WATCHDOG_CONTROL_PS_LO +: 3];
                    // A new kick wins over the clear of an old one
                    if (pwdata[`WPR_WATCHDOG_CONTROL_KICK]) begin
                        st_next.watchdog_control.kick = 1'b1;
                    end
                end
                wpr_pkg::wpr_sel_stat:
                    st_next.stat = st_reg.stat & ~pwdata[2:0];
                wpr_pkg::wpr_sel_mask:
                    st_next.mask = pwdata[2:0];
                wpr_pkg::wpr_sel_none: begin
                end
            endcase
        end

        // Power mode; deep stop takes precedence over idle
        unique case (st_reg.mode)
            wpr_pkg::wpr_mode_run: begin
                if (st_reg.power_control.deep) begin
                    st_next.mode = wpr_pkg::wpr_mode_pdown;
                end else if (st_reg.power_control.sleep) begin
                    st_next.mode = wpr_pkg::wpr_mode_idle;
                end
            end
            wpr_pkg::wpr_mode_idle: begin
                if (st_reg.power_control.deep) begin
                    st_next.mode = wpr_pkg::wpr_mode_pdown;
                end else if (cpu_irq) begin
                    st_next.mode = wpr_pkg::wpr_mode_run;
                    st_next.power_control.sleep = 1'b0;
                end
            end
            wpr_pkg::wpr_mode_pdown: begin
                st_next.mode = wpr_pkg::wpr_mode_pdown;
            end
            default: st_next.mode = wpr_pkg::wpr_mode_run;
        endcase

        // Watchdog reset is stretched over whole machine cycles
        if (wdt_fire) begin
            st_next.rst_cnt = `WPR_WDT_RST_MC;
        end else if (mc_tick && (st_reg.rst_cnt != 2'h0)) begin
            st_next.rst_cnt = st_reg.rst_cnt - 2'h1;
        end

        // Pin or watchdog reset: power and watchdog control to zero, cold flag kept; stat and mask keep their values
        if (in_reset) begin
            st_next.power_control = '0;
            st_next.power_control.cold = st_reg.power_control.cold;
            st_next.watchdog_control = '0;
            st_next.mode = wpr_pkg::wpr_mode_run;
        end

        // Events; a set in the clearing cycle survives
        st_next.pin_q = pin_rst;
        if (wdt_fire) begin
            st_next.stat[`WPR_EV_TIMEOUT] = 1'b1;
        end
        if (pin_rst && !st_reg.pin_q) begin
            st_next.stat[`WPR_EV_PINRST] = 1'b1;
        end
        if ((st_reg.mode == wpr_pkg::wpr_mode_idle) && cpu_irq &&
            !st_reg.power_control.deep) begin
            st_next.stat[`WPR_EV_WAKE] = 1'b1;
        end
        st_next.irq = |(st_next.stat & st_next.mask);

        st_next.sys_reset = pin_rst || (st_next.rst_cnt != 2'h0);
        st_next.cpu_clk_en = (st_next.mode == wpr_pkg::wpr_mode_run);
        st_next.periph_clk_en = (st_next.mode != wpr_pkg::wpr_mode_pdown);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.power_control.cold <= 1'b1;
            st_reg.cpu_clk_en <= 1'b1;
            st_reg.periph_clk_en <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign sys_reset = st_reg.sys_reset;
    assign cpu_clk_en = st_reg.cpu_clk_en;
    assign periph_clk_en = st_reg.periph_clk_en;
    assign irq = st_reg.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence kick_armed;
        kick_do && !in_reset && !kick_wr;
    endsequence

    sequence kick_done;
        !st_reg.watchdog_control.kick && (wdt_count == 14'h0000);
    endsequence

    sequence idle_wake;
        (st_reg.mode == wpr_pkg::wpr_mode_idle) && cpu_irq &&
            !st_reg.power_control.deep && !in_reset;
    endsequence

    kick_clears_a: assert property (
        kick_armed |=> kick_done)
        else $error("kick did not clear timer and kick bit");

    wdt_reset_a: assert property (
        wdt_fire |=> sys_reset [*8])
        else $error("watchdog time-out gave no system reset");

    reset_disables_a: assert property (
        in_reset |=> !st_reg.watchdog_control.run && (wdt_count == 14'h0000))
        else $error("reset left watchdog running");

    idle_stop_a: assert property (
        (st_reg.mode == wpr_pkg::wpr_mode_idle) &&
        !st_reg.watchdog_control.sleep_run |-> !wdt_tick)
        else $error("watchdog counted in idle without sleep-run");

    pdown_hold_a: assert property (
        (st_reg.mode == wpr_pkg::wpr_mode_pdown) && !in_reset |=>
        (st_reg.mode == wpr_pkg::wpr_mode_pdown) && !cpu_clk_en)
        else $error("deep stop left without reset");

    pdown_freeze_a: assert property (
        (st_reg.mode == wpr_pkg::wpr_mode_pdown) && !in_reset |=>
        $stable(wdt_count))
        else $error("watchdog moved in deep stop");

    cold_keep_a: assert property (
        in_reset && !access |=> st_reg.power_control.cold == $past(st_reg.power_control.cold))
        else $error("cold start flag changed by reset");

    div_two_a: assert property (
        osc_on |=> st_reg.phase != $past(st_reg.phase))
        else $error("internal clock not divided by two");

    pin_sample_a: assert property (
        $rose(pin_rst) |-> $past(state5_phase2_sample) && $past(pin_level))
        else $error("pin reset taken outside sampling phase");

    idle_wake_a: assert property (
        idle_wake |=> (st_reg.mode == wpr_pkg::wpr_mode_run) ##0
        cpu_clk_en && !st_reg.power_control.sleep)
        else $error("interrupt did not end idle");

    irq_level_a: assert property (
        irq == |(st_reg.stat & st_reg.mask))
        else $error("interrupt output disagrees with status");

    apb_wait_a: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("APB answer not after one wait state");
endmodule // wpr_top

//--- shared/wpr_defs.svh
`ifndef WPR_DEFS_SVH
`define WPR_DEFS_SVH

// Register indices; byte address is four times the index
`define WPR_IDX_POWER_CONTROL 8'h87
`define WPR_IDX_WATCHDOG_CONTROL 8'h8F
`define WPR_IDX_STAT 8'h90
`define WPR_IDX_MASK 8'h91

// Watchdog control fields
`define WPR_WATCHDOG_CONTROL_RUN 7
`define WPR_WATCHDOG_CONTROL_KICK 6
`define WPR_WATCHDOG_CONTROL_SLEEP 5
`define WPR_WATCHDOG_CONTROL_PS_LO 0

// Power control fields
`define WPR_POWER_CONTROL_COLD 4
`define WPR_POWER_CONTROL_UF1 3
`define WPR_POWER_CONTROL_UF0 2
`define WPR_POWER_CONTROL_DEEP 1
`define WPR_POWER_CONTROL_SLEEP 0

// Event status bits
`define WPR_EV_TIMEOUT 0
`define WPR_EV_PINRST 1
`define WPR_EV_WAKE 2

// Reset values
`define WPR_SFR_RST 8'h00
`define WPR_PORT_RST 8'hFF
`define WPR_SP_RST 8'h07

// Timing: one state is two oscillator periods, six states a cycle
`define WPR_OSC_NS 20
`define WPR_MC_OSC 12
`define WPR_LAST_STATE 3'h5
`define WPR_SAMPLE_STATE 3'h4
`define WPR_PIN_MC 2'h2
`define WPR_WDT_RST_MC 2'h2
`define WPR_WDT_MAX 14'h3FFF
`endif

//--- shared/wpr_pkg.sv
package wpr_pkg;
    typedef enum logic [1:0] {
        wpr_mode_run = 2'b00,
        wpr_mode_idle = 2'b01,
        wpr_mode_pdown = 2'b10
    } wpr_mode_t;

    typedef enum logic [2:0] {
        wpr_sel_none = 3'b000,
        wpr_sel_power_control = 3'b001,
        wpr_sel_watchdog_control = 3'b010,
        wpr_sel_stat = 3'b011,
        wpr_sel_mask = 3'b100
    } wpr_sel_t;

    typedef struct packed {
        logic run;
        logic kick;
        logic sleep_run;
        logic [2:0] ps;
    } wpr_watchdog_control_t;

    typedef struct packed {
        logic cold;
        logic uf1;
        logic uf0;
        logic deep;
        logic sleep;
    } wpr_power_control_t;

    typedef struct packed {
        logic [7:0] presc;
        logic [13:0] cnt;
    } wpr_core_st_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic [1:0] hits;
        logic pin_rst;
    } wpr_filt_st_t;

    typedef struct packed {
        wpr_power_control_t power_control;
        wpr_watchdog_control_t watchdog_control;
        wpr_mode_t mode;
        logic phase;
        logic [2:0] stage;
        logic [1:0] rst_cnt;
        logic pin_q;
        logic [2:0] stat;
        logic [2:0] mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic sys_reset;
        logic cpu_clk_en;
        logic periph_clk_en;
        logic irq;
    } wpr_top_st_t;
endpackage

//--- logic/wpr_rst_filter.sv
`timescale 1ns/1ps
`include "wpr_defs.svh"
module wpr_rst_filter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rst_pin,
    input wire logic sample_en,
    output logic pin_level,
    output logic pin_rst
);
    wpr_pkg::wpr_filt_st_t st_reg;
    wpr_pkg::wpr_filt_st_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = rst_pin;
        st_next.sync2 = st_reg.sync1;
        // Samples count at the sampling phase, and on every clock while the oscillator is stopped
        if (sample_en) begin
            if (st_reg.sync2) begin
                if (st_reg.hits != `WPR_PIN_MC) begin
                    st_next.hits = st_reg.hits + 2'h1;
                end
            end else begin
                st_next.hits = 2'h0;
            end
            st_next.pin_rst = (st_next.hits == `WPR_PIN_MC);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pin_level = st_reg.sync2;
    assign pin_rst = st_reg.pin_rst;
endmodule // wpr_rst_filter

//--- logic/wpr_wdt_core.sv
`timescale 1ns/1ps
`include "wpr_defs.svh"
module wpr_wdt_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic tick,
    input wire logic [2:0] ps,
    output logic timeout,
    output logic [13:0] count
);
    wpr_pkg::wpr_core_st_t st_reg;
    wpr_pkg::wpr_core_st_t st_next;
    logic [7:0] mask;
    logic hit;

    // Select code to prescaler terminal mask, order PS2 PS1 PS0
    function automatic logic [7:0] presc_mask(input logic [2:0] sel);
        unique case (sel)
            3'b000: presc_mask = 8'h01;
            3'b010: presc_mask = 8'h03;
            3'b001: presc_mask = 8'h07;
            3'b011: presc_mask = 8'h0F;
            3'b100: presc_mask = 8'h1F;
            3'b101: presc_mask = 8'h3F;
            3'b110: presc_mask = 8'h7F;
            3'b111: presc_mask = 8'hFF;
        endcase
    endfunction

    always_comb begin
        mask = presc_mask(ps);
        hit = ((st_reg.presc & mask) == mask);
        // Machine cycle times divisor times 2^14
        timeout = tick && hit && (st_reg.cnt == `WPR_WDT_MAX);
        st_next = st_reg;
        if (clr) begin
            st_next = '0;
        end else if (tick) begin
            if (hit) begin
                st_next.presc = 8'h00;
                st_next.cnt = st_reg.cnt + 14'h0001;
            end else begin
                st_next.presc = st_reg.presc + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count = st_reg.cnt;
endmodule // wpr_wdt_core

//--- verif/watchdog_power_reset_control_tb.sv
`timescale 1ns/1ps
`include "wpr_defs.svh"
module watchdog_power_reset_control_tb;
    localparam logic [11:0] A_POWER_CONTROL = {2'b00, `WPR_IDX_POWER_CONTROL, 2'b00};
    localparam logic [11:0] A_WATCHDOG_CONTROL = {2'b00, `WPR_IDX_WATCHDOG_CONTROL, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, `WPR_IDX_STAT, 2'b00};
    localparam logic [11:0] A_MASK = {2'b00, `WPR_IDX_MASK, 2'b00};
    localparam logic [11:0] A_NONE = 12'h248;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rst_pin = 1'b0;
    logic cpu_irq = 1'b0;
    logic sys_reset;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic irq;
    logic [31:0] rd;
    logic err;
    int errors = 0;
    int cmp_count = 0;

    always #10 pclk = ~pclk;

    wpr_top dut (
        .pclk(pclk),
        .presetn(presetn),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rst_pin(rst_pin),
        .cpu_irq(cpu_irq),
        .sys_reset(sys_reset),
        .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en),
        .irq(irq)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t %s: seen %h expected %h", $time, what, seen,
                     exp);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; waits for pready, the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] addr,
                       input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        check(32'(n), 32'h2, "pready wait");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [11:0] addr, input logic [7:0] d);
        apb(1'b1, addr, {24'h000000, d});
        check({31'h0, err}, 32'h0, "write slverr");
    endtask

    task automatic rd_chk(input logic [11:0] addr, input logic [7:0] exp);
        apb(1'b0, addr, 32'h0);
        check({31'h0, err}, 32'h0, "read slverr");
        check(rd, {24'h000000, exp}, "read data");
    endtask

    task automatic wait_rst(input logic v, input int lim);
        int n;
        n = 0;
        while (sys_reset !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        check({31'h0, sys_reset}, {31'h0, v}, "system reset level");
    endtask

    task automatic clk_chk(input logic c, input logic p);
        check({30'h0, cpu_clk_en, periph_clk_en}, {30'h0, c, p},
              "clk enables");
    endtask

    initial begin
        #(20 * 20000);
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(A_POWER_CONTROL, 8'h10);
        rd_chk(A_WATCHDOG_CONTROL, `WPR_SFR_RST);
        rd_chk(A_STAT, 8'h00);
        rd_chk(A_MASK, 8'h00);
        clk_chk(1'b1, 1'b1);
        apb(1'b0, A_NONE, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped slverr");
        check(rd, 32'h0, "unmapped data");
        apb(1'b1, A_POWER_CONTROL | 12'h001, 32'h0000000C);
        check({31'h0, err}, 32'h1, "unaligned slverr");
        rd_chk(A_POWER_CONTROL, 8'h10);
        $display("test reset_values done");

        wr_reg(A_POWER_CONTROL, 8'h1C);
        rd_chk(A_POWER_CONTROL, 8'h1C);
        wr_reg(A_POWER_CONTROL, 8'h00);
        rd_chk(A_POWER_CONTROL, 8'h00);
        wr_reg(A_POWER_CONTROL, 8'h10);
        rd_chk(A_POWER_CONTROL, 8'h00);
        wr_reg(A_POWER_CONTROL, 8'h08);
        rd_chk(A_POWER_CONTROL, 8'h08);
        wr_reg(A_POWER_CONTROL, 8'h00);
        $display("test power_control done");

        for (int ps = 0; ps < 8; ps++) begin
            wr_reg(A_WATCHDOG_CONTROL, 8'h38 | 8'(ps));
            rd_chk(A_WATCHDOG_CONTROL, 8'h20 | 8'(ps));
        end
        wr_reg(A_WATCHDOG_CONTROL, 8'hC0);
        repeat (2 * `WPR_MC_OSC) @(posedge pclk);
        rd_chk(A_WATCHDOG_CONTROL, 8'h80);
        check({31'h0, sys_reset}, 32'h0, "no early reset");
        wr_reg(A_WATCHDOG_CONTROL, 8'h00);
        $display("test watchdog_control done");

        wr_reg(A_POWER_CONTROL, 8'h01);
        repeat (3) @(posedge pclk);
        clk_chk(1'b0, 1'b1);
        cpu_irq <= 1'b1;
        @(posedge pclk);
        cpu_irq <= 1'b0;
        repeat (3) @(posedge pclk);
        clk_chk(1'b1, 1'b1);
        rd_chk(A_POWER_CONTROL, 8'h00);
        rd_chk(A_STAT, 8'h04);
        check({31'h0, irq}, 32'h0, "irq masked");
        wr_reg(A_MASK, 8'h04);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h1, "irq unmasked");
        wr_reg(A_STAT, 8'h04);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0, "irq cleared");
        rd_chk(A_STAT, 8'h00);
        $display("test idle_wake done");

        wr_reg(A_WATCHDOG_CONTROL, 8'hA3);
        rd_chk(A_WATCHDOG_CONTROL, 8'hA3);
        wr_reg(A_POWER_CONTROL, 8'h0F);
        repeat (3) @(posedge pclk);
        clk_chk(1'b0, 1'b0);
        cpu_irq <= 1'b1;
        @(posedge pclk);
        cpu_irq <= 1'b0;
        repeat (3) @(posedge pclk);
        clk_chk(1'b0, 1'b0);
        rst_pin <= 1'b1;
        repeat (10) @(posedge pclk);
        rst_pin <= 1'b0;
        repeat (40) begin
            @(posedge pclk);
            check({31'h0, sys_reset}, 32'h0, "glitch reset");
        end
        rst_pin <= 1'b1;
        wait_rst(1'b1, 4 * `WPR_MC_OSC);
        repeat (3) @(posedge pclk);
        clk_chk(1'b1, 1'b1);
        rd_chk(A_POWER_CONTROL, 8'h00);
        rd_chk(A_WATCHDOG_CONTROL, 8'h00);
        wr_reg(A_POWER_CONTROL, 8'h0C);
        rd_chk(A_POWER_CONTROL, 8'h00);
        rst_pin <= 1'b0;
        wait_rst(1'b0, 3 * `WPR_MC_OSC);
        rd_chk(A_STAT, 8'h02);
        wr_reg(A_STAT, 8'h02);
        rd_chk(A_STAT, 8'h00);
        rd_chk(A_WATCHDOG_CONTROL, 8'h00);
        $display("test deep_stop_pin_reset done");
        wrap_up();
    end
endmodule // watchdog_power_reset_control_tb
